// file: inc/lf_rx_pkg.sv
package lf_rx_pkg;

    // Register addresses on the special function bus
    localparam logic [7:0] ADDR_STATUS = 8'hA4;
    localparam logic [7:0] ADDR_BYTE = 8'hA5;
    localparam logic [7:0] ADDR_FILTER = 8'hB2;
    localparam logic [7:0] ADDR_DIV_LOW = 8'hB3;
    localparam logic [7:0] ADDR_CD_MODE = 8'hB5;
    localparam logic [7:0] ADDR_CONTROL = 8'hF9;

    // Status register bit positions
    localparam int ST_SERIAL_BIT = 0;
    localparam int ST_BIT_PEND = 1;
    localparam int ST_BIT_OVF = 2;
    localparam int ST_BYTE_PEND = 3;
    localparam int ST_BYTE_OVF = 4;
    localparam int ST_RAW_CHIP = 5;
    localparam int ST_DEC_ERR = 6;
    localparam int ST_RAW_CARRIER = 7;

    // Carrier filter and carrier detector mode fields
    localparam int FILT_TIME_LSB = 4;
    localparam int FILT_MODE_LSB = 0;
    localparam int CDM_EXTEND = 7;
    localparam int CDM_CAL_SEL_LSB = 4;
    localparam int CDM_CAL_EN = 3;
    localparam int CDM_FREEZE = 2;
    localparam int CDM_HOLD_LSB = 0;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [1:0] RST_FIELD2 = 2'h0;
    localparam logic [2:0] RST_FIELD3 = 3'h0;

    // Hold time base: two low-power periods, doubled per code step
    localparam logic [4:0] HOLD_BASE_TICKS = 5'h02;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        FM_OFF = 2'h0,
        FM_AFTER_ON = 2'h1,
        FM_ALWAYS = 2'h2,
        FM_RESERVED = 2'h3
    } filter_mode_t;

    // Plain storage registers of the rest of the receiver
    localparam int N_PLAIN = 14;
    localparam logic [7:0] PLAIN_ADDR [N_PLAIN] = '{
        8'hA6, 8'hA7, 8'hAF, 8'hB4, 8'hB6, 8'hB7, 8'hBE,
        8'hBF, 8'hC5, 8'hC6, 8'hC7, 8'hCE, 8'hCF, 8'hF9
    };
    localparam logic [7:0] PLAIN_RST [N_PLAIN] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
        8'hFF, 8'h64, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00
    };

endpackage

// file: core/lf_sync2.sv
`timescale 1ns/1ns
`default_nettype none

module lf_sync2 #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // Two flops per bit; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_q[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule // lf_sync2

`default_nettype wire

// file: core/lf_receiver_data_and_carrier_cfg.sv
`timescale 1ns/1ns
`default_nettype none

module lf_receiver_data_and_carrier_cfg (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Wakeup event and low-power oscillator tick
    input wire logic wakeup,
    input wire logic lp_tick,
    // Decoder and front end
    input wire logic dec_bit_valid,
    input wire logic dec_bit,
    input wire logic dec_violation,
    input wire logic raw_chip_in,
    input wire logic raw_carrier_in,
    // Carrier detector configuration
    output logic [1:0] filter_time_sel,
    output logic [1:0] filter_mode_sel,
    output logic on_time_extend,
    output logic [2:0] cal_threshold_sel,
    output logic threshold_cal_enable,
    output logic threshold_freeze_enable,
    output logic [1:0] carrier_hold_time,
    output logic [7:0] divider_low_bits,
    // Derived carrier behaviour
    output logic carrier_held,
    output logic filter_active,
    output logic rx_keep_on
);

    logic serial_rx_bit_q;
    logic bit_pending_flag_q;
    logic bit_overflow_flag_q;
    logic byte_pending_flag_q;
    logic byte_overflow_flag_q;
    logic decode_error_flag_q;
    logic [7:0] lf_rx_byte_q;
    logic [6:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic [4:0] hold_cnt_q;
    logic carrier_prev_q;
    logic [7:0] plain_q [lf_rx_pkg::N_PLAIN];
    logic raw_chip_bit;
    logic raw_carrier_bit;

    // Raw levels are asynchronous to the core clock
    lf_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({raw_carrier_in, raw_chip_in}),
        .sync_out({raw_carrier_bit, raw_chip_bit})
    );

    // Address decode
    wire hit_status = (sfr_addr == lf_rx_pkg::ADDR_STATUS);
    wire hit_byte = (sfr_addr == lf_rx_pkg::ADDR_BYTE);
    wire hit_filter = (sfr_addr == lf_rx_pkg::ADDR_FILTER);
    wire hit_div_low = (sfr_addr == lf_rx_pkg::ADDR_DIV_LOW);
    wire hit_cd_mode = (sfr_addr == lf_rx_pkg::ADDR_CD_MODE);
    wire rd_status = sfr_rd && hit_status;
    wire rd_byte = sfr_rd && hit_byte;
    wire wr_status = sfr_wr && hit_status;
    wire byte_done = dec_bit_valid && (bit_cnt_q == lf_rx_pkg::BYTE_LAST_BIT);

    // Status image; raw bits are live levels
    wire [7:0] status_image = {
        raw_carrier_bit,
        decode_error_flag_q,
        raw_chip_bit,
        byte_overflow_flag_q,
        byte_pending_flag_q,
        bit_overflow_flag_q,
        bit_pending_flag_q,
        serial_rx_bit_q
    };
    wire [7:0] filter_image = {2'b00, filter_time_sel, 2'b00, filter_mode_sel};
    wire [7:0] cd_mode_image = {on_time_extend, cal_threshold_sel, threshold_cal_enable,
                                threshold_freeze_enable, carrier_hold_time};

    // Software clear: writing 0 to an overflow or error bit clears it
    wire clr_bit_ovf = wr_status && !sfr_wdata[lf_rx_pkg::ST_BIT_OVF];
    wire clr_byte_ovf = wr_status && !sfr_wdata[lf_rx_pkg::ST_BYTE_OVF];
    wire clr_dec_err = wr_status && !sfr_wdata[lf_rx_pkg::ST_DEC_ERR];

    // Serial bit interface; a new bit wins over a clearing read
    always_ff @(posedge clk) begin
        if (rst || wakeup) begin
            serial_rx_bit_q <= 1'b0;
            bit_pending_flag_q <= 1'b0;
            bit_overflow_flag_q <= 1'b0;
        end else begin
            if (dec_bit_valid) begin
                serial_rx_bit_q <= dec_bit;
            end
            bit_pending_flag_q <= dec_bit_valid || (bit_pending_flag_q && !rd_status);
            if (dec_bit_valid && bit_pending_flag_q && !rd_status) begin
                bit_overflow_flag_q <= 1'b1;
            end else if (clr_bit_ovf) begin
                bit_overflow_flag_q <= 1'b0;
            end
        end
    end

    // Byte assembly, first received bit lands in bit 7
    always_ff @(posedge clk) begin
        if (rst || wakeup) begin
            lf_rx_byte_q <= lf_rx_pkg::RST_ZERO;
            shift_q <= 7'h00;
            bit_cnt_q <= 3'h0;
            byte_pending_flag_q <= 1'b0;
            byte_overflow_flag_q <= 1'b0;
        end else begin
            if (dec_bit_valid) begin
                shift_q <= {shift_q[5:0], dec_bit};
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (byte_done) begin
                lf_rx_byte_q <= {shift_q, dec_bit};
            end
            byte_pending_flag_q <= byte_done || (byte_pending_flag_q && !rd_byte);
            if (byte_done && byte_pending_flag_q && !rd_byte) begin
                byte_overflow_flag_q <= 1'b1;
            end else if (clr_byte_ovf) begin
                byte_overflow_flag_q <= 1'b0;
            end
        end
    end

    // Decode error is sticky until written as 0 or cleared by wakeup
    always_ff @(posedge clk) begin
        if (rst || wakeup) begin
            decode_error_flag_q <= 1'b0;
        end else if (dec_violation) begin
            decode_error_flag_q <= 1'b1;
        end else if (clr_dec_err) begin
            decode_error_flag_q <= 1'b0;
        end
    end

    // Carrier filter register; wakeup leaves both fields alone
    always_ff @(posedge clk) begin
        if (rst) begin
            filter_time_sel <= lf_rx_pkg::RST_FIELD2;
            filter_mode_sel <= lf_rx_pkg::RST_FIELD2;
        end else if (sfr_wr && hit_filter) begin
            filter_time_sel <= sfr_wdata[lf_rx_pkg::FILT_TIME_LSB +: 2];
            filter_mode_sel <= sfr_wdata[lf_rx_pkg::FILT_MODE_LSB +: 2];
        end
    end

    // Carrier detector mode; threshold field is stored as written
    always_ff @(posedge clk) begin
        if (rst) begin
            on_time_extend <= 1'b0;
            cal_threshold_sel <= lf_rx_pkg::RST_FIELD3;
            threshold_cal_enable <= 1'b0;
            threshold_freeze_enable <= 1'b0;
            carrier_hold_time <= lf_rx_pkg::RST_FIELD2;
        end else if (sfr_wr && hit_cd_mode) begin
            on_time_extend <= sfr_wdata[lf_rx_pkg::CDM_EXTEND];
            cal_threshold_sel <= sfr_wdata[lf_rx_pkg::CDM_CAL_SEL_LSB +: 3];
            threshold_cal_enable <= sfr_wdata[lf_rx_pkg::CDM_CAL_EN];
            threshold_freeze_enable <= sfr_wdata[lf_rx_pkg::CDM_FREEZE];
            carrier_hold_time <= sfr_wdata[lf_rx_pkg::CDM_HOLD_LSB +: 2];
        end
    end

    // Divider low byte
    always_ff @(posedge clk) begin
        if (rst) begin
            divider_low_bits <= lf_rx_pkg::RST_ZERO;
        end else if (sfr_wr && hit_div_low) begin
            divider_low_bits <= sfr_wdata;
        end
    end

    // Storage for the neighbouring receiver registers, control at F9 included
    genvar gi;
    generate
        for (gi = 0; gi < lf_rx_pkg::N_PLAIN; gi++) begin : g_plain
            always_ff @(posedge clk) begin
                if (rst) begin
                    plain_q[gi] <= lf_rx_pkg::PLAIN_RST[gi];
                end else if (sfr_wr && sfr_addr == lf_rx_pkg::PLAIN_ADDR[gi]) begin
                    plain_q[gi] <= sfr_wdata;
                end
            end
        end
    endgenerate

    // Read mux; unmapped addresses answer zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = lf_rx_pkg::RST_ZERO;
        if (hit_status) begin
            rd_mux = status_image;
        end else if (hit_byte) begin
            rd_mux = lf_rx_byte_q;
        end else if (hit_filter) begin
            rd_mux = filter_image;
        end else if (hit_div_low) begin
            rd_mux = divider_low_bits;
        end else if (hit_cd_mode) begin
            rd_mux = cd_mode_image;
        end else begin
            for (int k = 0; k < lf_rx_pkg::N_PLAIN; k++) begin
                if (sfr_addr == lf_rx_pkg::PLAIN_ADDR[k]) begin
                    rd_mux = plain_q[k];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sfr_rdata <= lf_rx_pkg::RST_ZERO;
        end else if (sfr_rd) begin
            sfr_rdata <= rd_mux;
        end
    end

    // Hold counter reloads on the falling carrier, counts low-power ticks
    wire [4:0] hold_ticks = 5'(lf_rx_pkg::HOLD_BASE_TICKS << carrier_hold_time);
    wire carrier_fall = carrier_prev_q && !raw_carrier_bit;
    always_ff @(posedge clk) begin
        if (rst) begin
            carrier_prev_q <= 1'b0;
            hold_cnt_q <= 5'h00;
        end else begin
            carrier_prev_q <= raw_carrier_bit;
            if (carrier_fall) begin
                hold_cnt_q <= hold_ticks;
            end else if (lp_tick && hold_cnt_q != 5'h00) begin
                hold_cnt_q <= hold_cnt_q - 5'h01;
            end
        end
    end

    // Filter on/off per mode; reserved mode leaves filtering off
    logic filter_d;
    always_comb begin
        case (lf_rx_pkg::filter_mode_t'(filter_mode_sel))
            lf_rx_pkg::FM_ALWAYS: filter_d = 1'b1;
            lf_rx_pkg::FM_AFTER_ON: filter_d = !carrier_held;
            default: filter_d = 1'b0;
        endcase
    end

    // Derived outputs, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            carrier_held <= 1'b0;
            filter_active <= 1'b0;
            rx_keep_on <= 1'b0;
        end else begin
            carrier_held <= raw_carrier_bit || carrier_fall || hold_cnt_q != 5'h00;
            filter_active <= filter_d;
            rx_keep_on <= on_time_extend && carrier_held;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_bit_pending_set: assert property (dec_bit_valid && !wakeup |=>
        bit_pending_flag_q && serial_rx_bit_q == $past(dec_bit))
        else $error("bit pending not set on new bit");
    a_bit_overflow_set: assert property (
        dec_bit_valid && bit_pending_flag_q && !rd_status && !wakeup |=> bit_overflow_flag_q)
        else $error("bit overflow missed");
    a_byte_assembled: assert property (byte_done && !wakeup |=>
        byte_pending_flag_q && lf_rx_byte_q == {$past(shift_q), $past(dec_bit)})
        else $error("byte not delivered");
    a_pending_read_clear: assert property (
        rd_byte && !byte_done && !wakeup |=> !byte_pending_flag_q)
        else $error("byte pending not cleared by read");
    a_wakeup_zero: assert property (wakeup |=>
        lf_rx_byte_q == 8'h00 && status_image[4:0] == 5'h00 && !decode_error_flag_q)
        else $error("wakeup did not clear status");
    a_decode_error: assert property (dec_violation && !wakeup |=> decode_error_flag_q)
        else $error("decode error lost");
    a_raw_sync_delay: assert property (
        $past(rst, 2) == 1'b0 |-> raw_carrier_bit == $past(raw_carrier_in, 2))
        else $error("raw carrier latency wrong");
    a_divider_write: assert property (sfr_wr && hit_div_low |=>
        divider_low_bits == $past(sfr_wdata))
        else $error("divider low byte not written");
    a_filter_always: assert property (filter_mode_sel == 2'h2 |=> filter_active)
        else $error("filter not active in always mode");
    a_keep_on_rule: assert property (
        !on_time_extend ##1 !on_time_extend |-> !rx_keep_on)
        else $error("keep on without extension");
    a_status_readback: assert property (sfr_rd && hit_status |=>
        sfr_rdata == $past(status_image))
        else $error("status read data mismatch");

    c_byte_done: cover property (byte_done ##1 byte_pending_flag_q);
    c_bit_overflow: cover property (!bit_overflow_flag_q ##1 bit_overflow_flag_q);
    c_hold_expire: cover property (carrier_held ##1 !carrier_held);

endmodule // lf_receiver_data_and_carrier_cfg

`default_nettype wire

// file: tb/lf_front_model.sv
`timescale 1ns/1ns
`default_nettype none

module lf_front_model (
    // Clock
    input wire logic clk,
    // Decoder side
    output logic dec_bit_valid,
    output logic dec_bit,
    output logic dec_violation,
    // Analog side and low-power oscillator
    output logic raw_chip_in,
    output logic raw_carrier_in,
    output logic lp_tick
);
    int unsigned lp_cnt = 0;

    // Tick one cycle in four, far faster than the real oscillator, keeps hold tests short
    initial begin
        {dec_bit_valid, dec_bit, dec_violation, raw_chip_in, raw_carrier_in, lp_tick} = '0;
        forever begin
            @(negedge clk);
            lp_cnt = (lp_cnt + 1) % 4;
            lp_tick = (lp_cnt == 0);
        end
    end

    // Bits back to back, first bit first; a released data line shows the inverse
    task automatic send_bits(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk);
            dec_bit_valid = 1'b1;
            dec_bit = v[i];
        end
        @(negedge clk);
        dec_bit_valid = 1'b0;
        dec_bit = ~dec_bit;
    endtask

    // One code violation pulse
    task automatic violate();
        @(negedge clk);
        dec_violation = 1'b1;
        @(negedge clk);
        dec_violation = 1'b0;
    endtask

    // Carrier and chip levels, unrelated to any strobe
    task automatic set_raw(input logic car, input logic chip);
        @(negedge clk);
        raw_carrier_in = car;
        raw_chip_in = chip;
    endtask
endmodule // lf_front_model

`default_nettype wire

// file: tb/tb_lf_receiver_data_and_carrier_cfg.sv
`timescale 1ns/1ns
`default_nettype none

module tb_lf_receiver_data_and_carrier_cfg;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_rd = 1'b0;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic wakeup = 1'b0;
    logic [7:0] sfr_rdata, divider_low_bits, v;
    logic [2:0] cal_threshold_sel;
    logic [1:0] filter_time_sel, filter_mode_sel, carrier_hold_time;
    logic on_time_extend, threshold_cal_enable, threshold_freeze_enable;
    logic carrier_held, filter_active, rx_keep_on;
    logic dec_bit_valid, dec_bit, dec_violation, raw_chip_in, raw_carrier_in, lp_tick;
    int error_cnt = 0;
    int n_compared = 0;
    // Expected receive state
    logic e_bit, e_bp, e_bov, e_dp, e_dov, e_err;
    logic [7:0] e_shift, e_byte;
    int e_cnt;

    lf_receiver_data_and_carrier_cfg i_dut (.clk, .rst, .sfr_addr, .sfr_rd, .sfr_wr,
        .sfr_wdata, .sfr_rdata, .wakeup, .lp_tick, .dec_bit_valid, .dec_bit,
        .dec_violation, .raw_chip_in, .raw_carrier_in, .filter_time_sel, .filter_mode_sel,
        .on_time_extend, .cal_threshold_sel, .threshold_cal_enable, .threshold_freeze_enable,
        .carrier_hold_time, .divider_low_bits, .carrier_held, .filter_active, .rx_keep_on);

    lf_front_model i_front (.clk, .dec_bit_valid, .dec_bit, .dec_violation, .raw_chip_in,
        .raw_carrier_in, .lp_tick);

    // Free-running 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Write-zero clears the sticky flags of the status register
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        if (a == lf_rx_pkg::ADDR_STATUS) begin
            e_bov = e_bov & d[2];
            e_dov = e_dov & d[4];
            e_err = e_err & d[6];
        end
    endtask

    // Reads clear the matching pending flag
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        check(what, sfr_rdata, exp);
        if (a == lf_rx_pkg::ADDR_STATUS) e_bp = 1'b0;
        if (a == lf_rx_pkg::ADDR_BYTE) e_dp = 1'b0;
    endtask

    function automatic logic [7:0] exp_st(input logic car, input logic chip);
        return {car, e_err, chip, e_dov, e_dp, e_bov, e_bp, e_bit};
    endfunction

    function automatic logic exp_fa(input logic [1:0] m, input logic held);
        return (m == 2'h2) || (m == 2'h1 && !held);
    endfunction

    task automatic st_chk();
        rdc(lf_rx_pkg::ADDR_STATUS, exp_st(1'b0, 1'b0), "status");
    endtask

    // Bits enter byte at bit 0 and shift up, eight to a byte
    task automatic push(input logic [15:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            e_bov = e_bov | e_bp;
            e_bit = w[i];
            e_bp = 1'b1;
            e_shift = {e_shift[6:0], w[i]};
            e_cnt++;
            if (e_cnt == 8) begin
                e_dov = e_dov | e_dp;
                e_byte = e_shift;
                e_dp = 1'b1;
                e_cnt = 0;
            end
        end
        i_front.send_bits(w, n);
    endtask

    task automatic clear_exp();
        {e_bit, e_bp, e_bov, e_dp, e_dov, e_err, e_shift, e_byte} = '0;
        e_cnt = 0;
    endtask

    // Watchdog well beyond the several hundred cycles of the sequence
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial begin
        void'($urandom(32'h92F9));
        clear_exp();
        repeat (2) @(negedge clk);
        rst = 1'b0;
        st_chk();
        rdc(lf_rx_pkg::ADDR_BYTE, 8'h00, "byte");
        rdc(lf_rx_pkg::ADDR_FILTER, 8'h00, "filter");
        rdc(lf_rx_pkg::ADDR_DIV_LOW, 8'h00, "div");
        rdc(lf_rx_pkg::ADDR_CD_MODE, 8'h00, "cdmode");
        for (int i = 0; i < lf_rx_pkg::N_PLAIN; i++) begin
            v = 8'($urandom);
            rdc(lf_rx_pkg::PLAIN_ADDR[i], lf_rx_pkg::PLAIN_RST[i], "plain_rst");
            wr(lf_rx_pkg::PLAIN_ADDR[i], v);
            rdc(lf_rx_pkg::PLAIN_ADDR[i], v, "plain");
        end
        wr(8'h10, 8'h5A);
        rdc(8'h10, 8'h00, "unmapped");
        $display("test reset_map done");
        // Every filter mode, random other fields except the threshold select, held at zero
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            wr(lf_rx_pkg::ADDR_DIV_LOW, v);
            rdc(lf_rx_pkg::ADDR_DIV_LOW, v, "div");
            check("div_out", divider_low_bits, v);
            v = 8'($urandom);
            v[6:4] = 3'h0;
            wr(lf_rx_pkg::ADDR_CD_MODE, v);
            rdc(lf_rx_pkg::ADDR_CD_MODE, v, "cdmode");
            check("extend", 8'(on_time_extend), 8'(v[7]));
            check("cal_en", 8'(threshold_cal_enable), 8'(v[3]));
            check("freeze", 8'(threshold_freeze_enable), 8'(v[2]));
            check("hold", 8'(carrier_hold_time), 8'(v[1:0]));
            check("cal_sel", 8'(cal_threshold_sel), 8'h00);
            v = 8'($urandom);
            v[1:0] = i[1:0];
            wr(lf_rx_pkg::ADDR_FILTER, v);
            rdc(lf_rx_pkg::ADDR_FILTER, v & 8'h33, "filter");
            check("ftime", 8'(filter_time_sel), 8'(v[5:4]));
            check("fmode", 8'(filter_mode_sel), 8'(v[1:0]));
            check("factive", 8'(filter_active), 8'(exp_fa(v[1:0], 1'b0)));
        end
        $display("test config done");
        push(16'h0001, 1);
        st_chk();
        st_chk();
        push(16'h0002, 2);
        st_chk();
        wr(lf_rx_pkg::ADDR_STATUS, 8'hFB);
        st_chk();
        push(16'h00A5, 5);
        st_chk();
        rdc(lf_rx_pkg::ADDR_BYTE, e_byte, "byte");
        push(16'($urandom), 16);
        st_chk();
        rdc(lf_rx_pkg::ADDR_BYTE, e_byte, "byte");
        i_front.violate();
        e_err = 1'b1;
        st_chk();
        wr(lf_rx_pkg::ADDR_STATUS, 8'hBF);
        st_chk();
        wr(lf_rx_pkg::ADDR_STATUS, 8'h00);
        repeat (10) begin
            push(16'($urandom), 1 + $urandom % 12);
            st_chk();
            rdc(lf_rx_pkg::ADDR_BYTE, e_byte, "byte");
        end
        $display("test data_path done");
        wr(lf_rx_pkg::ADDR_FILTER, 8'h01);
        for (int h = 0; h < 4; h++) begin
            wr(lf_rx_pkg::ADDR_CD_MODE, {6'h20, h[1:0]});
            i_front.set_raw(1'b1, h[0]);
            repeat (4) @(negedge clk);
            rdc(lf_rx_pkg::ADDR_STATUS, exp_st(1'b1, h[0]), "raw");
            check("held", 8'(carrier_held), 8'h01);
            check("keep_on", 8'(rx_keep_on), 8'h01);
            check("factive", 8'(filter_active), 8'h00);
            i_front.set_raw(1'b0, 1'b0);
            repeat ((2 << h) * 4 - 4) @(negedge clk);
            check("held_on", 8'(carrier_held), 8'h01);
            repeat (16) @(negedge clk);
            check("held_off", 8'(carrier_held), 8'h00);
            check("keep_off", 8'(rx_keep_on), 8'h00);
            check("factive", 8'(filter_active), 8'h01);
        end
        $display("test carrier done");
        push(16'($urandom), 5);
        wr(lf_rx_pkg::ADDR_FILTER, 8'hFF);
        @(negedge clk);
        wakeup = 1'b1;
        @(negedge clk);
        wakeup = 1'b0;
        clear_exp();
        st_chk();
        rdc(lf_rx_pkg::ADDR_BYTE, 8'h00, "byte");
        rdc(lf_rx_pkg::ADDR_FILTER, 8'h33, "filter");
        push(16'h00C3, 8);
        rdc(lf_rx_pkg::ADDR_BYTE, 8'hC3, "byte");
        $display("test wakeup done");
        summarize();
    end
endmodule // tb_lf_receiver_data_and_carrier_cfg

`default_nettype wire
